/* common/uls_pkg.sv */
/*
 package for the line and modem status block: register map, field
 positions, reset values and the interrupt source layout.
 assumes a 32-bit apb with one aligned word per register.
*/
package uls_pkg;
   localparam int          ULS_AW          = 5;
   localparam int          ULS_DW          = 32;
   localparam logic [4:0]  ULS_OFF_LINE    = 5'h00;
   localparam logic [4:0]  ULS_OFF_MODEM   = 5'h04;
   localparam logic [4:0]  ULS_OFF_MCTRL   = 5'h08;
   localparam logic [4:0]  ULS_OFF_ISTAT   = 5'h0c;
   localparam logic [4:0]  ULS_OFF_IMASK   = 5'h10;
   // line_status_reg fields
   localparam int          ULS_LS_DR       = 0;
   localparam int          ULS_LS_OE       = 1;
   localparam int          ULS_LS_PE       = 2;
   localparam int          ULS_LS_FE       = 3;
   // modem_state_reg fields
   localparam int          ULS_MS_DCTS     = 0;
   localparam int          ULS_MS_DDSR     = 1;
   localparam int          ULS_MS_TERI     = 2;
   localparam int          ULS_MS_DCD      = 3;
   localparam int          ULS_MS_CTS      = 4;
   localparam int          ULS_MS_DSR      = 5;
   localparam int          ULS_MS_RI       = 6;
   localparam int          ULS_MS_CD       = 7;
   // modem_ctrl_reg fields
   localparam int          ULS_MC_DTR      = 0;
   localparam int          ULS_MC_RTS      = 1;
   localparam int          ULS_MC_OUT1     = 2;
   localparam int          ULS_MC_OUTA     = 3;
   localparam int          ULS_MC_LOOP     = 4;
   localparam int          ULS_MC_W        = 5;
   localparam logic [4:0]  ULS_MC_RST      = 5'h00;
   // interrupt sources
   localparam int          ULS_IRQ_MODEM   = 0;
   localparam int          ULS_IRQ_OVR     = 1;
   localparam int          ULS_IRQ_RXERR   = 2;
   localparam int          ULS_IRQ_RXDATA  = 3;
   localparam int          ULS_IRQ_W       = 4;
   localparam logic [3:0]  ULS_IMASK_RST   = 4'h0;
   localparam int          ULS_SYNC_STAGES = 2;
endpackage

/* hdl/uls_sync.sv */
/*
 two-flop synchroniser for a group of independent level inputs.
 assumes each bit is a slow level; no bus coherency across bits.
*/
`timescale 1ns/1ps
module uls_sync
   import uls_pkg::*;
#(
   parameter int         W   = 4,
   parameter logic [W-1:0] RST = '0
)
(
   input  wire logic         clk_sys_i,
   input  wire logic         rst_b_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_q <= RST;
         q_o    <= RST;
      end
      else
      begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule

/* hdl/uls_status.sv */
/*
 line and modem status logic for one uart channel, with an apb slave,
 a modem control register, loop-back and a maskable interrupt.
 assumes the receiver and receive fifo sit on clk_sys_i and report the
 head character's error flags; modem pins are asynchronous, active low.
*/
// Added by the designer: register access over APB and the address map.
// Functional notes
// - framing flag is 1 when the head character had no valid stop bit.
// - parity flag is 1 when the head character had bad parity, else 0.
// - a character done while the fifo is full sets overrun, unwritten.
// - data-ready reads 1 while any received character is held.
// - the change bits set on a modem input change, bit 2 on a call alert rise only; clear on a read.
// - bit 7 is inverted carrier detect, or user output a in loop-back.
// - bit 6 is inverted call alert, or user output one in loop-back.
// - bit 5 is inverted data-set-ready, or terminal-ready in loop-back.
// - bit 4 is inverted clear-to-send, or request-to-send in loop-back.
// - bits 3, 1 and 0 record any change of carrier, dsr and cts.
// - bit 2 sets only when the call alert input goes from 0 to 1.
// - a modem status interrupt is requested while any change bit is 1.
`timescale 1ns/1ps
module uls_status
   import uls_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_b_i,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ULS_AW-1:0] paddr,
   input  wire logic [ULS_DW-1:0] pwdata,
   output logic      [ULS_DW-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              rx_done_i,
   input  wire logic              rx_fifo_full_i,
   input  wire logic              rx_fifo_empty_i,
   input  wire logic              rx_head_ferr_i,
   input  wire logic              rx_head_perr_i,
   output logic                   rx_fifo_wr_o,
   input  wire logic              carrier_detect_in_n_i,
   input  wire logic              call_alert_in_n_i,
   input  wire logic              dsr_in_n_i,
   input  wire logic              cts_in_n_i,
   output logic                   dtr_n_o,
   output logic                   rts_n_o,
   output logic                   user_out_one_n_o,
   output logic                   user_out_a_n_o,
   output logic                   modem_irq_o,
   output logic                   irq_o
);
   logic [3:0]            pin_s;
   logic [ULS_MC_W-1:0]   mctrl_q;
   logic [ULS_IRQ_W-1:0]  istat_q;
   logic [ULS_IRQ_W-1:0]  imask_q;
   logic [ULS_IRQ_W-1:0]  ev;
   logic [3:0]            delta_q;
   logic [3:0]            delta_set;
   logic [3:0]            live_prev_q;
   logic                  started_q;
   logic                  ovr_q;
   logic [7:0]            line_v;
   logic [7:0]            modem_v;
   logic [3:0]            live;
   logic [ULS_DW-1:0]     rd_v;
   logic                  map_hit;
   logic                  setup;
   logic                  acc;
   logic                  wr_acc;
   logic                  rd_line;
   logic                  rd_modem;
   logic                  lerr_prev_q;
   logic                  rx_drop;

   // pins order: cd, ri, dsr, cts; reset to inactive (high)
   uls_sync #(
      .W   (4),
      .RST (4'hf)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_b_i   (rst_b_i),
      .d_i       ({carrier_detect_in_n_i, call_alert_in_n_i,
                   dsr_in_n_i, cts_in_n_i}),
      .q_o       (pin_s)
   );

   // apb decode; one wait-free access phase
   assign setup    = psel && !penable;
   assign acc      = psel && penable && pready;
   assign wr_acc   = acc && pwrite && !pslverr;
   assign rd_line  = acc && !pwrite && (paddr == ULS_OFF_LINE);
   assign rd_modem = acc && !pwrite && (paddr == ULS_OFF_MODEM);

   always_comb
   begin
      map_hit = 1'b1;
      rd_v    = '0;
      case (paddr)
         ULS_OFF_LINE:  rd_v[7:0] = line_v;
         ULS_OFF_MODEM: rd_v[7:0] = modem_v;
         ULS_OFF_MCTRL: rd_v[ULS_MC_W-1:0] = mctrl_q;
         ULS_OFF_ISTAT: rd_v[ULS_IRQ_W-1:0] = istat_q;
         ULS_OFF_IMASK: rd_v[ULS_IRQ_W-1:0] = imask_q;
         default:       map_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup && !map_hit;
         if (setup && !pwrite)
            prdata <= rd_v;
         else if (acc)
            prdata <= '0;
      end
   end

   // line status
   always_comb
   begin
      line_v             = '0;
      line_v[ULS_LS_DR]  = !rx_fifo_empty_i;
      line_v[ULS_LS_OE]  = ovr_q;
      line_v[ULS_LS_PE]  = rx_head_perr_i && !rx_fifo_empty_i;
      line_v[ULS_LS_FE]  = rx_head_ferr_i && !rx_fifo_empty_i;
   end

   assign rx_drop = rx_done_i && rx_fifo_full_i;

   // only the overrun that was actually read is cleared
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ovr_q <= 1'b0;
      else if (rx_drop)
         ovr_q <= 1'b1;
      else if (rd_line && prdata[ULS_LS_OE])
         ovr_q <= 1'b0;
   end

   // a full fifo is never written, so its contents stay intact
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rx_fifo_wr_o <= 1'b0;
      else
         rx_fifo_wr_o <= rx_done_i && !rx_fifo_full_i;
   end

   // modem control register and its pins; pins idle high in loop-back
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         mctrl_q <= ULS_MC_RST;
      else if (wr_acc && paddr == ULS_OFF_MCTRL)
         mctrl_q <= pwdata[ULS_MC_W-1:0];
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         dtr_n_o          <= 1'b1;
         rts_n_o          <= 1'b1;
         user_out_one_n_o <= 1'b1;
         user_out_a_n_o   <= 1'b1;
      end
      else
      begin
         dtr_n_o          <= !mctrl_q[ULS_MC_DTR] || mctrl_q[ULS_MC_LOOP];
         rts_n_o          <= !mctrl_q[ULS_MC_RTS] || mctrl_q[ULS_MC_LOOP];
         user_out_one_n_o <= !mctrl_q[ULS_MC_OUT1] || mctrl_q[ULS_MC_LOOP];
         user_out_a_n_o   <= !mctrl_q[ULS_MC_OUTA] || mctrl_q[ULS_MC_LOOP];
      end
   end

   // live modem state, order cd, ri, dsr, cts
   always_comb
   begin
      if (mctrl_q[ULS_MC_LOOP])
         live = {mctrl_q[ULS_MC_OUTA], mctrl_q[ULS_MC_OUT1],
                 mctrl_q[ULS_MC_DTR], mctrl_q[ULS_MC_RTS]};
      else
         live = ~pin_s;
   end

   // change detection starts one cycle after reset so that the reset
   // value of the history does not fake a change
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         live_prev_q <= '0;
         started_q   <= 1'b0;
      end
      else
      begin
         live_prev_q <= live;
         started_q   <= 1'b1;
      end
   end

   // ri bit is the inverted pin, so pin 0->1 is a falling live bit
   always_comb
   begin
      delta_set              = '0;
      if (started_q)
      begin
         delta_set[ULS_MS_DCD]  = live[3] ^ live_prev_q[3];
         delta_set[ULS_MS_TERI] = live_prev_q[2] && !live[2];
         delta_set[ULS_MS_DDSR] = live[1] ^ live_prev_q[1];
         delta_set[ULS_MS_DCTS] = live[0] ^ live_prev_q[0];
      end
   end

   // clear only the bits the read returned; a new set always wins
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         delta_q <= '0;
      else if (rd_modem)
         delta_q <= (delta_q & ~prdata[3:0]) | delta_set;
      else
         delta_q <= delta_q | delta_set;
   end

   assign modem_v = {live, delta_q};

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         modem_irq_o <= 1'b0;
      else
         modem_irq_o <= |delta_q;
   end

   // interrupt events: sticky, write one to clear, set beats clear
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         lerr_prev_q <= 1'b0;
      else
         lerr_prev_q <= line_v[ULS_LS_PE] || line_v[ULS_LS_FE];
   end

   always_comb
   begin
      ev                 = '0;
      ev[ULS_IRQ_MODEM]  = |delta_set;
      ev[ULS_IRQ_OVR]    = rx_drop;
      ev[ULS_IRQ_RXERR]  = (line_v[ULS_LS_PE] || line_v[ULS_LS_FE])
                           && !lerr_prev_q;
      ev[ULS_IRQ_RXDATA] = rx_done_i && !rx_fifo_full_i;
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         istat_q <= '0;
      else if (wr_acc && paddr == ULS_OFF_ISTAT)
         istat_q <= (istat_q & ~pwdata[ULS_IRQ_W-1:0]) | ev;
      else
         istat_q <= istat_q | ev;
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         imask_q <= ULS_IMASK_RST;
      else if (wr_acc && paddr == ULS_OFF_IMASK)
         imask_q <= pwdata[ULS_IRQ_W-1:0];
   end

   // level output lags the status bits by one cycle
   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(istat_q & imask_q);
   end

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   a_fe_head_read: assert property (
      setup && !pwrite && paddr == ULS_OFF_LINE
      |=> prdata[ULS_LS_FE] == ($past(rx_head_ferr_i)
                                && !$past(rx_fifo_empty_i)))
      else $error("framing flag read wrong");

   a_pe_head_read: assert property (
      setup && !pwrite && paddr == ULS_OFF_LINE
      |=> prdata[ULS_LS_PE] == ($past(rx_head_perr_i)
                                && !$past(rx_fifo_empty_i)))
      else $error("parity flag read wrong");

   a_overrun_set: assert property (
      rx_done_i && rx_fifo_full_i |=> ovr_q && !rx_fifo_wr_o)
      else $error("overrun not flagged or full fifo written");

   a_fifo_write: assert property (
      rx_done_i && !rx_fifo_full_i
      |=> rx_fifo_wr_o ##1 (!rx_fifo_wr_o || $past(rx_done_i)))
      else $error("accepted character not written once");

   a_ready_read: assert property (
      setup && !pwrite && paddr == ULS_OFF_LINE
      |=> prdata[ULS_LS_DR] == !$past(rx_fifo_empty_i))
      else $error("data ready read wrong");

   a_delta_clear: assert property (
      rd_modem && delta_set == 4'h0
      |=> (delta_q & $past(prdata[3:0])) == 4'h0)
      else $error("change bits not cleared by read");

   a_loop_state: assert property (
      setup && !pwrite && paddr == ULS_OFF_MODEM && mctrl_q[ULS_MC_LOOP]
      |=> prdata[ULS_MS_CD] == $past(mctrl_q[ULS_MC_OUTA])
          && prdata[ULS_MS_RI] == $past(mctrl_q[ULS_MC_OUT1])
          && prdata[ULS_MS_DSR] == $past(mctrl_q[ULS_MC_DTR])
          && prdata[ULS_MS_CTS] == $past(mctrl_q[ULS_MC_RTS]))
      else $error("loop-back state wrong");

   a_cd_change: assert property (
      started_q && !mctrl_q[ULS_MC_LOOP] && $stable(mctrl_q[ULS_MC_LOOP])
      && $changed(pin_s[3])
      |=> delta_q[ULS_MS_DCD])
      else $error("carrier change not recorded");

   // the pin itself rising from 0 to 1 must be recorded
   a_ring_rise: assert property (
      started_q && !mctrl_q[ULS_MC_LOOP] && $stable(mctrl_q[ULS_MC_LOOP])
      && $rose(pin_s[2]) |=> delta_q[ULS_MS_TERI])
      else $error("ring rise not recorded");

   a_ring_fall: assert property (
      started_q && !mctrl_q[ULS_MC_LOOP] && $stable(mctrl_q[ULS_MC_LOOP])
      && $fell(pin_s[2]) && !delta_q[ULS_MS_TERI]
      |=> !delta_q[ULS_MS_TERI])
      else $error("ring bit set on falling input");

   a_modem_irq: assert property (
      delta_q != 4'h0 |=> modem_irq_o)
      else $error("modem interrupt not requested");

   a_set_wins: assert property (
      delta_set != 4'h0
      |=> (delta_q & $past(delta_set)) == $past(delta_set))
      else $error("change lost against read");
endmodule

/* verif/uls_modem_model.sv */
/*
 modem side model: drives the four active-low status pins of the
 status block from requested levels.
 assumes requests change just after a rising edge of clk_sys_i.
*/
`timescale 1ns/1ps
module uls_modem_model
(
   input  wire logic       clk_sys_i,
   input  wire logic [3:0] act_i,
   output logic            carrier_detect_in_n_o,
   output logic            call_alert_in_n_o,
   output logic            dsr_in_n_o,
   output logic            cts_in_n_o
);
   // pins idle high; a real modem moves them off the uart clock, so the
   // one-edge lag here does not test that the block synchronises them
   logic [3:0] lvl_q = 4'h0;

   always @(posedge clk_sys_i)
   begin
      lvl_q <= act_i;
   end

   assign carrier_detect_in_n_o = ~lvl_q[0];
   assign call_alert_in_n_o     = ~lvl_q[1];
   assign dsr_in_n_o            = ~lvl_q[2];
   assign cts_in_n_o            = ~lvl_q[3];
endmodule

/* verif/uls_status_tb_top.sv */
/*
 self-checking bench for the line and modem status block: apb master
 tasks, a receiver stub and the modem model on the far side.
 assumes the register map and latencies of the package and hand-over.
*/
`timescale 1ns/1ps
module uls_status_tb_top
   import uls_pkg::*;
;
   logic              clk_sys_i = 1'b0;
   logic              rst_b_i   = 1'b0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ULS_AW-1:0] paddr  = '0;
   logic [ULS_DW-1:0] pwdata = '0;
   logic [ULS_DW-1:0] prdata;
   logic              pready, pslverr;
   logic              rx_done = 1'b0, rx_full = 1'b0, rx_empty = 1'b1;
   logic              rx_ferr = 1'b0, rx_perr = 1'b0;
   logic              rx_wr;
   logic              cd_n, ri_n, dsr_n, cts_n;
   logic              dtr_n, rts_n, out1_n, outa_n, modem_irq, irq;
   logic [3:0]        act = 4'h0;
   logic [7:0]        exp_ms;
   logic [ULS_DW-1:0] rdat;
   logic              err;
   int                n_fail = 0;
   int                cmp_count = 0;

   always #4 clk_sys_i = ~clk_sys_i;

   uls_modem_model uls_modem_model_i (.clk_sys_i(clk_sys_i), .act_i(act),
      .carrier_detect_in_n_o(cd_n), .call_alert_in_n_o(ri_n),
      .dsr_in_n_o(dsr_n), .cts_in_n_o(cts_n));

   uls_status uls_status_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_done_i(rx_done), .rx_fifo_full_i(rx_full),
      .rx_fifo_empty_i(rx_empty), .rx_head_ferr_i(rx_ferr),
      .rx_head_perr_i(rx_perr), .rx_fifo_wr_o(rx_wr),
      .carrier_detect_in_n_i(cd_n), .call_alert_in_n_i(ri_n),
      .dsr_in_n_i(dsr_n), .cts_in_n_i(cts_n), .dtr_n_o(dtr_n),
      .rts_n_o(rts_n), .user_out_one_n_o(out1_n), .user_out_a_n_o(outa_n),
      .modem_irq_o(modem_irq), .irq_o(irq));

   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // the answer is taken at the edge where pready is seen high, never
   // earlier, so a slave with wait states would still be read right
   task automatic apb(input logic w, input logic [ULS_AW-1:0] a,
                      input logic [ULS_DW-1:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rdat = prdata;
      err  = pslverr;
      if (n >= 16)
         chk(32'h1, 32'h0);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [ULS_AW-1:0] a, input logic [7:0] exp);
      apb(1'b0, a, '0);
      chk(rdat, {24'h0, exp});
   endtask

   // one receiver completion; write strobe stands one cycle later
   task automatic pulse(input logic full, input logic exp_wr);
      @(posedge clk_sys_i);
      rx_full <= full;
      rx_done <= 1'b1;
      @(posedge clk_sys_i);
      rx_done <= 1'b0;
      @(posedge clk_sys_i);
      chk(rx_wr, exp_wr);
   endtask

   initial
   begin
      #(20000 * 8);
      n_fail++;
      summarize();
   end

   initial
   begin
      cyc(4);
      rst_b_i <= 1'b1;
      rd(ULS_OFF_LINE, 8'h00);
      rd(ULS_OFF_MODEM, 8'h00);
      rd(ULS_OFF_MCTRL, 8'h00);
      rd(ULS_OFF_IMASK, 8'h00);
      apb(1'b0, 5'h14, '0);
      chk({31'h0, err}, 32'h1);
      chk(rdat, 32'h0);
      // interrupt: raised, masked, cleared
      apb(1'b1, ULS_OFF_IMASK, 32'h08);
      pulse(1'b0, 1'b1);
      cyc(2);
      chk(irq, 1'b1);
      rd(ULS_OFF_ISTAT, 8'h08);
      apb(1'b1, ULS_OFF_IMASK, 32'h00);
      cyc(2);
      chk(irq, 1'b0);
      apb(1'b1, ULS_OFF_IMASK, 32'h08);
      apb(1'b1, ULS_OFF_ISTAT, 32'h08);
      cyc(2);
      chk(irq, 1'b0);
      // overrun: full fifo refuses the character, flag clears on read
      rx_empty <= 1'b0;
      pulse(1'b1, 1'b0);
      rd(ULS_OFF_LINE, 8'h03);
      rd(ULS_OFF_LINE, 8'h01);
      rx_ferr <= 1'b1;
      rd(ULS_OFF_LINE, 8'h09);
      rx_ferr <= 1'b0;
      rx_perr <= 1'b1;
      rd(ULS_OFF_LINE, 8'h05);
      rx_perr <= 1'b0;
      rx_empty <= 1'b1;
      rd(ULS_OFF_LINE, 8'h00);
      // pins in order carrier, call alert, dsr, cts
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk_sys_i);
         act[i] <= 1'b1;
         cyc(8);
         chk(modem_irq, i != 1);
         exp_ms = (8'h80 >> i) | ((i == 1) ? 8'h00 : 8'h08 >> i);
         rd(ULS_OFF_MODEM, exp_ms);
         rd(ULS_OFF_MODEM, 8'h80 >> i);
         @(posedge clk_sys_i);
         act[i] <= 1'b0;
         cyc(8);
         rd(ULS_OFF_MODEM, 8'h08 >> i);
         cyc(2);
         chk(modem_irq, 1'b0);
      end
      // loop-back: live bits follow the control register instead
      apb(1'b1, ULS_OFF_MCTRL, 32'h1f);
      cyc(6);
      chk({dtr_n, rts_n, out1_n, outa_n}, 4'hf);
      rd(ULS_OFF_MODEM, 8'hfb);
      apb(1'b1, ULS_OFF_MCTRL, 32'h10);
      cyc(6);
      rd(ULS_OFF_MODEM, 8'h0f);
      apb(1'b1, ULS_OFF_MCTRL, 32'h0f);
      cyc(6);
      chk({dtr_n, rts_n, out1_n, outa_n}, 4'h0);
      rd(ULS_OFF_MODEM, 8'h00);
      summarize();
   end
endmodule
